/* File: logic/epm_pkg.sv */
package epm_pkg;
	// Pin function selects for the two multiplexed pins
	typedef enum logic [1:0] {
		EPM_FN_EEPROM = 2'h0,
		EPM_FN_GPO = 2'h1,
		EPM_FN_MON_A = 2'h2,
		EPM_FN_MON_B = 2'h3
	} epm_fn_e;

	typedef struct packed {
		epm_fn_e data_fn;
		epm_fn_e clock_fn;
		logic gpo_three;
		logic gpo_four;
	} epm_cfg_s;

	typedef struct packed {
		logic tx_en;
		logic tx_clk;
		logic rx_dv;
		logic rx_clk;
	} epm_mii_s;

	typedef struct packed {
		logic data_out;
		logic data_oe;
		logic clock_out;
		logic select_n;
	} epm_ee_s;

	typedef enum logic [1:0] {
		EPM_RST_POR = 2'h0,
		EPM_RST_RUN = 2'h1,
		EPM_RST_HOLD = 2'h2
	} epm_rst_e;

	localparam logic EPM_STRAP_32 = 1'h1;
	localparam logic EPM_SEL_IDLE_N = 1'h1;
	localparam int EPM_REF_HZ = 25000000;
	localparam int EPM_POR_NS = 1000;
	localparam int EPM_CLK_NS = 100;
	localparam int EPM_POR_CYC = (EPM_POR_NS + EPM_CLK_NS - 1) / EPM_CLK_NS;
	localparam logic [3:0] EPM_POR_LAST = 4'(EPM_POR_CYC - 1);
	localparam logic [3:0] EPM_CNT_ZERO = 4'h0;
	localparam logic [3:0] EPM_CNT_ONE = 4'h1;
endpackage

/* File: logic/epm_sync.sv */
`timescale 1ns/1ps
module epm_sync import epm_pkg::*; #(
	parameter int W = 1
) (
	// Clocking
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = clk_en ? d : meta_r;
		q_nxt = clk_en ? meta_r : q_r;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_r <= q_nxt;
		end
	end

	assign q = q_r;
endmodule

/* File: logic/epm_pin_mux.sv */
`timescale 1ns/1ps
// What this block does
// - Data, clock, select pins serve serial EEPROM
// - Data pin as output three or TX monitor
// - Clock pin as output four or RX monitor
// - Output-three and four have no input path
// - Latch bus width strap at reset release
// - Low reset input asserts logic_rst and idles the pins
// - Unconnected reset pulled high, power-on fallback
// - Logic runs from core clock; crystal clocks only the MII copies and their two reset stages
module epm_pin_mux import epm_pkg::*; (
	// Core clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Crystal reference, clocks the MII monitor side
	input wire logic crystal_in,
	// Reset pin, externally pulled high when open
	input wire logic active_low_reset_in,
	// Configuration and EEPROM engine
	input wire epm_cfg_s cfg,
	input wire epm_ee_s ee_drive,
	// Internal MII signals, crystal domain
	input wire epm_mii_s mii,
	// Pins
	input wire logic eeprom_data_io_in,
	output logic eeprom_data_io_out,
	output logic eeprom_data_io_oe,
	output logic eeprom_serial_clock,
	output logic eeprom_select_n,
	// Status
	output logic eeprom_data_in,
	output logic bus_width_32,
	output logic logic_rst
);
	// Crystal domain: register MII copies so the crossing sees clean levels
	epm_mii_s mii_r;
	epm_mii_s mii_nxt;
	epm_mii_s mii_s;
	logic x_rst_meta_r;
	logic x_rst_r;

	always_comb begin
		mii_nxt = mii;
	end

	// Crystal side reset from core reset, two stages
	always_ff @(posedge crystal_in) begin
		x_rst_meta_r <= sys_rst;
		x_rst_r <= x_rst_meta_r;
	end

	always_ff @(posedge crystal_in) begin
		if (x_rst_r) begin
			mii_r <= '0;
		end else begin
			mii_r <= mii_nxt;
		end
	end

	// Monitor levels into core domain; MII clocks alias slowly, debug use only
	epm_sync #(.W(4)) u_mii_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.d(mii_r),
		.q(mii_s)
	);

	// Reset pin and data pin come from outside, synchronise both
	logic [1:0] pin_s;
	epm_sync #(.W(2)) u_pin_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.d({active_low_reset_in, eeprom_data_io_in}),
		.q(pin_s)
	);

	// Reset sequencer: power-on count, then follow the pin
	epm_rst_e st_r;
	epm_rst_e st_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic rst_out_r;
	logic rst_out_nxt;
	logic strap_r;
	logic strap_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		rst_out_nxt = rst_out_r;
		strap_nxt = strap_r;
		unique case (st_r)
			EPM_RST_POR: begin
				rst_out_nxt = 1'h1;
				if (cnt_r == EPM_POR_LAST) begin
					st_nxt = EPM_RST_RUN;
					rst_out_nxt = 1'h0;
					strap_nxt = pin_s[0];
				end else begin
					cnt_nxt = 4'(cnt_r + EPM_CNT_ONE);
				end
			end
			EPM_RST_RUN: begin
				if (!pin_s[1]) begin
					st_nxt = EPM_RST_HOLD;
					rst_out_nxt = 1'h1;
				end
			end
			EPM_RST_HOLD: begin
				if (pin_s[1]) begin
					st_nxt = EPM_RST_RUN;
					rst_out_nxt = 1'h0;
					strap_nxt = pin_s[0];
				end
			end
			default: begin
				st_nxt = EPM_RST_POR;
				cnt_nxt = EPM_CNT_ZERO;
				rst_out_nxt = 1'h1;
			end
		endcase
		if (!clk_en) begin
			st_nxt = st_r;
			cnt_nxt = cnt_r;
			rst_out_nxt = rst_out_r;
			strap_nxt = strap_r;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_r <= EPM_RST_POR;
			cnt_r <= EPM_CNT_ZERO;
			rst_out_r <= 1'h1;
			strap_r <= EPM_STRAP_32;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			rst_out_r <= rst_out_nxt;
			strap_r <= strap_nxt;
		end
	end

	// Pin multiplexer
	epm_ee_s pin_r;
	epm_ee_s pin_nxt;
	logic din_r;
	logic din_nxt;
	logic ee_mode;

	always_comb begin
		ee_mode = (cfg.data_fn == EPM_FN_EEPROM) && (cfg.clock_fn == EPM_FN_EEPROM);
		pin_nxt.data_oe = 1'h1;
		pin_nxt.data_out = 1'h0;
		pin_nxt.clock_out = 1'h0;
		pin_nxt.select_n = ee_mode ? ee_drive.select_n : EPM_SEL_IDLE_N;
		unique case (cfg.data_fn)
			EPM_FN_EEPROM: begin
				pin_nxt.data_out = ee_drive.data_out;
				pin_nxt.data_oe = ee_drive.data_oe;
			end
			EPM_FN_GPO: pin_nxt.data_out = cfg.gpo_three;
			EPM_FN_MON_A: pin_nxt.data_out = mii_s.tx_en;
			EPM_FN_MON_B: pin_nxt.data_out = mii_s.tx_clk;
		endcase
		unique case (cfg.clock_fn)
			EPM_FN_EEPROM: pin_nxt.clock_out = ee_drive.clock_out;
			EPM_FN_GPO: pin_nxt.clock_out = cfg.gpo_four;
			EPM_FN_MON_A: pin_nxt.clock_out = mii_s.rx_dv;
			EPM_FN_MON_B: pin_nxt.clock_out = mii_s.rx_clk;
		endcase
		// Only the EEPROM function on the data pin samples it
		din_nxt = (cfg.data_fn == EPM_FN_EEPROM) ? pin_s[0] : din_r;
		if (rst_out_r) begin
			pin_nxt.data_out = 1'h0;
			pin_nxt.data_oe = 1'h0;
			pin_nxt.clock_out = 1'h0;
			pin_nxt.select_n = EPM_SEL_IDLE_N;
		end
		if (!clk_en) begin
			pin_nxt = pin_r;
			din_nxt = din_r;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_r <= '{data_out: 1'h0, data_oe: 1'h0, clock_out: 1'h0,
				select_n: EPM_SEL_IDLE_N};
			din_r <= 1'h0;
		end else begin
			pin_r <= pin_nxt;
			din_r <= din_nxt;
		end
	end

	assign eeprom_data_io_out = pin_r.data_out;
	assign eeprom_data_io_oe = pin_r.data_oe;
	assign eeprom_serial_clock = pin_r.clock_out;
	assign eeprom_select_n = pin_r.select_n;
	assign eeprom_data_in = din_r;
	assign bus_width_32 = strap_r;
	assign logic_rst = rst_out_r;

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	sel_idle_mux_a: assert property ($past(clk_en) && !$past(rst_out_r) &&
		($past(cfg.data_fn) != EPM_FN_EEPROM) |-> eeprom_select_n)
		else $error("select active while data pin muxed");
	sel_idle_clk_a: assert property ($past(clk_en) &&
		($past(cfg.clock_fn) != EPM_FN_EEPROM) |-> eeprom_select_n)
		else $error("select active while clock pin muxed");
	general_output_three_drive_a: assert property (clk_en && !rst_out_r && cfg.data_fn == EPM_FN_GPO
		|=> eeprom_data_io_oe && eeprom_data_io_out == $past(cfg.gpo_three))
		else $error("output three not driven");
	general_output_four_drive_a: assert property (clk_en && !rst_out_r && cfg.clock_fn == EPM_FN_GPO
		|=> eeprom_serial_clock == $past(cfg.gpo_four))
		else $error("output four not driven");
	no_input_a: assert property (clk_en && cfg.data_fn != EPM_FN_EEPROM
		|=> $stable(eeprom_data_in))
		else $error("data sampled while pin is output");
	strap_hold_a: assert property (st_r == EPM_RST_RUN |=> $stable(bus_width_32))
		else $error("strap changed outside reset");
	pin_reset_a: assert property (clk_en && st_r == EPM_RST_RUN && !pin_s[1]
		|=> logic_rst)
		else $error("reset pin ignored");
	por_len_a: assert property ($fell(sys_rst) |-> logic_rst [*8])
		else $error("power-on reset too short");
	reset_idle_a: assert property (clk_en && logic_rst |=> eeprom_select_n && !eeprom_data_io_oe)
		else $error("pins active during reset");

	por_done_c: cover property (st_r == EPM_RST_POR ##1 st_r == EPM_RST_RUN);
	pin_rst_c: cover property (st_r == EPM_RST_HOLD ##1 st_r == EPM_RST_RUN);
	mon_tx_c: cover property (!logic_rst && cfg.data_fn == EPM_FN_MON_B);
	general_output_four_c: cover property (!logic_rst && cfg.clock_fn == EPM_FN_GPO && cfg.gpo_four);
endmodule

/* File: sim/epm_ee_model.sv */
`timescale 1ns/1ps
module epm_ee_model (
	// Memory pins
	input wire logic select_n,
	input wire logic sclk,
	input wire logic host_out,
	input wire logic host_oe,
	// Board strap resistor level
	input wire logic strap,
	output logic pin
);
	logic bit_r = 1'h0;

	// New bit on each rise while selected, so stale data shows up
	always @(posedge sclk) begin
		if (!select_n) begin
			bit_r <= ~bit_r;
		end
	end

	always_comb begin
		if (host_oe) begin
			pin = host_out;
		end else if (!select_n) begin
			pin = bit_r;
		end else begin
			pin = strap;
		end
	end
endmodule

/* File: sim/tb_epm_pin_mux.sv */
`timescale 1ns/1ps
module tb_epm_pin_mux import epm_pkg::*;;
	logic clock, sys_rst, clk_en, crystal_in, rst_in_n, strap, exp_bit;
	logic pin, d_out, d_oe, sclk, sel_n, d_in, bw32, lrst;
	epm_cfg_s cfg;
	epm_ee_s ee;
	epm_mii_s mii;
	int num_errors = 0;
	int samples_checked = 0;

	epm_pin_mux i_epm_pin_mux (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
		.crystal_in(crystal_in), .active_low_reset_in(rst_in_n), .cfg(cfg),
		.ee_drive(ee), .mii(mii), .eeprom_data_io_in(pin), .eeprom_data_io_out(d_out),
		.eeprom_data_io_oe(d_oe), .eeprom_serial_clock(sclk), .eeprom_select_n(sel_n),
		.eeprom_data_in(d_in), .bus_width_32(bw32), .logic_rst(lrst));
	epm_ee_model i_epm_ee_model (.select_n(sel_n), .sclk(sclk), .host_out(d_out),
		.host_oe(d_oe), .strap(strap), .pin(pin));

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic chk(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wait_run();
		for (int i = 0; i < 30 && lrst !== 1'h0; i++) begin
			cyc(1);
		end
	endtask

	// Status is only read after reset, nothing is driven before that
	task automatic t_reset();
		wait_run();
		chk(lrst, 1'h0);
		chk(bw32, 1'h1);
		chk(sel_n, 1'h1);
		chk(d_oe, 1'h0);
	endtask

	task automatic t_eeprom();
		@(posedge clock);
		ee <= '{1'h0, 1'h0, 1'h0, 1'h0};
		cyc(2);
		chk(sel_n, 1'h0);
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			ee.clock_out <= 1'h1;
			cyc(2);
			chk(sclk, 1'h1);
			@(posedge clock);
			ee.clock_out <= 1'h0;
			exp_bit = ~exp_bit;
			cyc(5);
			chk(d_in, exp_bit);
		end
	endtask

	// Engine still asks for select: the mux must override it
	task automatic t_gpo();
		@(posedge clock);
		cfg <= '{EPM_FN_GPO, EPM_FN_GPO, ~exp_bit, 1'h1};
		cyc(2);
		chk(d_out, ~exp_bit);
		chk(d_oe, 1'h1);
		chk(sclk, 1'h1);
		chk(sel_n, 1'h1);
		cyc(4);
		chk(d_in, exp_bit);
		@(posedge clock);
		cfg <= '{EPM_FN_EEPROM, EPM_FN_GPO, 1'h0, 1'h0};
		cyc(2);
		chk(sclk, 1'h0);
		chk(sel_n, 1'h1);
	endtask

	task automatic t_mon(input epm_fn_e fn, input epm_mii_s m, input logic e);
		@(posedge clock);
		cfg <= '{fn, fn, 1'h0, 1'h0};
		mii <= m;
		cyc(1);
		for (int i = 0; i < 20 && (d_out !== e || sclk !== e); i++) begin
			cyc(1);
		end
		chk(d_out, e);
		chk(sclk, e);
		chk(sel_n, 1'h1);
	endtask

	// Clock enable low must freeze the pins against a new setting
	task automatic t_hold();
		@(posedge clock);
		cfg <= '{EPM_FN_GPO, EPM_FN_EEPROM, 1'h0, 1'h0};
		cyc(2);
		chk(d_out, 1'h0);
		chk(sel_n, 1'h1);
		@(posedge clock);
		clk_en <= 1'h0;
		cfg <= '{EPM_FN_EEPROM, EPM_FN_EEPROM, 1'h0, 1'h0};
		cyc(3);
		chk(d_oe, 1'h1);
		chk(sel_n, 1'h1);
		@(posedge clock);
		clk_en <= 1'h1;
		cyc(2);
		chk(sel_n, 1'h0);
		chk(d_oe, 1'h0);
	endtask

	task automatic t_strap();
		@(posedge clock);
		cfg <= '{EPM_FN_EEPROM, EPM_FN_EEPROM, 1'h0, 1'h0};
		ee <= '{1'h0, 1'h0, 1'h0, 1'h0};
		strap <= 1'h0;
		rst_in_n <= 1'h0;
		cyc(5);
		chk(lrst, 1'h1);
		chk(sel_n, 1'h1);
		@(posedge clock);
		rst_in_n <= 1'h1;
		cyc(2);
		wait_run();
		chk(lrst, 1'h0);
		chk(bw32, 1'h0);
	endtask

	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end

	// Unrelated phase to the core clock
	initial begin
		crystal_in = 1'h0;
		#37;
		forever #80 crystal_in = ~crystal_in;
	end

	initial begin
		repeat (3000) @(posedge clock);
		num_errors++;
		summarize();
	end

	initial begin
		sys_rst = 1'h1;
		clk_en = 1'h1;
		rst_in_n = 1'h1;
		strap = 1'h1;
		exp_bit = 1'h0;
		cfg = '{EPM_FN_EEPROM, EPM_FN_EEPROM, 1'h0, 1'h0};
		ee = '{1'h0, 1'h0, 1'h0, 1'h1};
		mii = 4'h0;
		repeat (8) @(posedge clock);
		sys_rst <= 1'h0;
		t_reset();
		t_eeprom();
		t_gpo();
		t_mon(EPM_FN_MON_A, 4'hA, 1'h1);
		t_mon(EPM_FN_MON_B, 4'hA, 1'h0);
		t_mon(EPM_FN_MON_B, 4'h5, 1'h1);
		t_hold();
		t_strap();
		summarize();
	end
endmodule
